/* File: common/led_sink_pkg.sv */
// Package with constants, register map and decode helpers of the dual LED sink block.
// Overview of operation
// R1: Range code 0 disables a channel's sink; brightness then has no effect.
// R2: Range code 1 enables a 3.2 mA full scale with 0.1 mA steps.
// R3: Range code 2 enables a 6.4 mA full scale with 0.2 mA steps.
// R4: Range code 3 enables a 12.8 mA full scale with 0.4 mA steps.
// R5: On-current is brightness plus one times the step; code 0x1f is full scale.
// R6: Invert clear: sink on from period start for the duty length, then off.
// R7: Invert set: sink off from period start for the duty length, then on.
// R8: Blink period is period field plus one times 0.5 s, 0.5 s to 8 s.
// R9: Duty is duty field plus one sixteenths of the period; 0xf never toggles.
// R10: Reset returns period field to zero and duty field to 0xf.
// R11: Reset returns range to disabled, invert to zero, brightness to 0x04.
// R12: Channel one has its own period and duty register, decoded like channel two.
// R13: Channel one has its own range, invert and brightness register, same decode.
// R14: Global sink enable must be set for either sink to conduct.
// R15: Blink logic runs from a 64 Hz root clock, 10 % high, readable in status.
// R16: Channels count root ticks, 32 per period step, restarting each period.
package led_sink_pkg;

  // ****************************************************************
  // Clocks and timing
  // ****************************************************************
  localparam int unsigned CLK_FREQ_HZ      = 125_000_000;
  localparam int unsigned ROOT_FREQ_HZ     = 64;
  localparam int unsigned ROOT_DUTY_PCT    = 10;
  localparam int unsigned ROOT_DIV_CYCLES  = CLK_FREQ_HZ / ROOT_FREQ_HZ;
  localparam int unsigned ROOT_HIGH_CYCLES = ROOT_DIV_CYCLES * ROOT_DUTY_PCT / 100;
  localparam int unsigned PERIOD_STEP_MS   = 500;
  localparam int unsigned TICKS_PER_STEP   = PERIOD_STEP_MS * ROOT_FREQ_HZ / 1000;
  localparam int unsigned PHASE_W          = 10;

  // ****************************************************************
  // Register map (index; byte address is four times the index)
  // ****************************************************************
  localparam int unsigned  APB_AW          = 12;
  localparam logic [9:0]   IDX_SINK1_LEVEL = 10'h040;
  localparam logic [9:0]   IDX_SINK1_TIME  = 10'h041;
  localparam logic [9:0]   IDX_SINK2_LEVEL = 10'h042;
  localparam logic [9:0]   IDX_SINK2_TIME  = 10'h043;
  localparam logic [9:0]   IDX_SINK_TOP    = 10'h044;
  localparam int unsigned  RANGE_LSB       = 6;
  localparam int unsigned  INVERT_BIT      = 5;
  localparam int unsigned  PERIOD_LSB      = 4;
  localparam int unsigned  GLOBAL_EN_BIT   = 0;
  localparam int unsigned  ROOT_STAT_BIT   = 1;
  localparam logic [7:0]   LEVEL_RST       = 8'h04;
  localparam logic [7:0]   TIMING_RST      = 8'h0f;
  localparam logic         GLOBAL_EN_RST   = 1'h0;

  typedef enum logic [1:0] {
    RANGE_OFF  = 2'h0,
    RANGE_3P2  = 2'h1,
    RANGE_6P4  = 2'h2,
    RANGE_12P8 = 2'h3
  } range_t;

  typedef enum logic [1:0] {
    APB_IDLE   = 2'h1,
    APB_ACCESS = 2'h2
  } apb_state_t;

  // Sink current in units of 0.1 mA; zero when the range is off.
  function automatic logic [7:0] sink_current_code(input logic [1:0] range, input logic [4:0] brt);
    logic [7:0] steps;
    steps = {3'h0, brt} + 8'h01;
    case (range)
      RANGE_3P2:  sink_current_code = steps; // [R2]
      RANGE_6P4:  sink_current_code = steps << 1; // [R3]
      RANGE_12P8: sink_current_code = steps << 2; // [R4]
      default:    sink_current_code = 8'h00;
    endcase
  endfunction : sink_current_code

  function automatic logic [PHASE_W-1:0] period_ticks(input logic [3:0] period);
    period_ticks = PHASE_W'(({6'h00, period} + 10'h001) * TICKS_PER_STEP);
  endfunction : period_ticks

  function automatic logic [PHASE_W-1:0] duty_ticks(input logic [3:0] period, input logic [3:0] duty);
    // The product reaches 8192 for the longest period, so it is formed at 32 bits.
    duty_ticks = PHASE_W'(((32'(duty) + 32'd1) * 32'(period_ticks(period))) / 32'd16);
  endfunction : duty_ticks

endpackage : led_sink_pkg

/* File: design/dual_led_sink_blink_pwm.sv */
// Top of the dual LED sink blink block: APB registers, root clock and two channels.
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ns
module dual_led_sink_blink_pwm
  import led_sink_pkg::*;
#(
  parameter int unsigned ROOT_DIV  = ROOT_DIV_CYCLES,
  parameter int unsigned ROOT_HIGH = ROOT_HIGH_CYCLES
) (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              sys_rst,
  // APB slave
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Sink drive, current in units of 0.1 mA
  output logic                   led_sink_out1,
  output logic [7:0]             sink_current_ch1,
  output logic                   led_sink_out2,
  output logic [7:0]             sink_current_ch2
);

  localparam int unsigned ROOT_CW = $clog2(ROOT_DIV);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  apb_state_t         apb_state_reg;
  logic [9:0]         reg_index;
  logic               index_known;
  logic               setup_take;
  logic               write_fire;
  logic [7:0]         read_byte;
  logic [7:0]         sink1_level_config_reg;
  logic [7:0]         sink1_blink_timing_reg;
  logic [7:0]         sink2_level_config_reg;
  logic [7:0]         sink2_blink_timing_reg;
  logic               global_sink_enable_reg;
  logic [ROOT_CW-1:0] root_cnt_reg;
  logic               root_clk_reg;
  logic               root_tick_reg;
  logic               first_cycle_reg;

  logic [1:0]         range_select_ch1;
  logic [1:0]         range_select_ch2;
  logic               polarity_invert_ch1;
  logic               polarity_invert_ch2;
  logic [4:0]         brightness_level_ch1;
  logic [4:0]         brightness_level_ch2;
  logic [3:0]         blink_period_ch1;
  logic [3:0]         blink_period_ch2;
  logic [3:0]         blink_duty_ch1;
  logic [3:0]         blink_duty_ch2;

  // ****************************************************************
  // Field decode
  // ****************************************************************
  assign range_select_ch1     = sink1_level_config_reg[RANGE_LSB+1:RANGE_LSB]; // [R13]
  assign polarity_invert_ch1  = sink1_level_config_reg[INVERT_BIT];
  assign brightness_level_ch1 = sink1_level_config_reg[4:0];
  assign range_select_ch2     = sink2_level_config_reg[RANGE_LSB+1:RANGE_LSB];
  assign polarity_invert_ch2  = sink2_level_config_reg[INVERT_BIT];
  assign brightness_level_ch2 = sink2_level_config_reg[4:0];
  assign blink_period_ch1     = sink1_blink_timing_reg[PERIOD_LSB+3:PERIOD_LSB]; // [R12]
  assign blink_duty_ch1       = sink1_blink_timing_reg[3:0];
  assign blink_period_ch2     = sink2_blink_timing_reg[PERIOD_LSB+3:PERIOD_LSB]; // [R8]
  assign blink_duty_ch2       = sink2_blink_timing_reg[3:0];

  // ****************************************************************
  // APB slave
  // ****************************************************************
  // Every transfer gets exactly one access cycle with pready high.
  assign reg_index   = paddr[APB_AW-1:2];
  assign index_known = (reg_index >= IDX_SINK1_LEVEL) && (reg_index <= IDX_SINK_TOP);
  assign setup_take  = (apb_state_reg == APB_IDLE) && psel && !penable;
  assign write_fire  = (apb_state_reg == APB_ACCESS) && psel && penable && pwrite && index_known && pstrb[0];

  always_comb begin
    case (reg_index)
      IDX_SINK1_LEVEL: read_byte = sink1_level_config_reg;
      IDX_SINK1_TIME:  read_byte = sink1_blink_timing_reg;
      IDX_SINK2_LEVEL: read_byte = sink2_level_config_reg;
      IDX_SINK2_TIME:  read_byte = sink2_blink_timing_reg;
      IDX_SINK_TOP:    read_byte = {6'h00, root_clk_reg, global_sink_enable_reg}; // [R15]
      default:         read_byte = 8'h00;
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      apb_state_reg <= APB_IDLE;
    end else begin
      case (apb_state_reg)
        APB_IDLE:   apb_state_reg <= setup_take ? APB_ACCESS : APB_IDLE;
        APB_ACCESS: apb_state_reg <= (psel && penable) ? APB_IDLE : APB_ACCESS;
        default:    apb_state_reg <= APB_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (setup_take) begin
      pready  <= 1'b1;
      pslverr <= !index_known;
      prdata  <= pwrite ? 32'h0000_0000 : {24'h00_0000, read_byte};
    end else if (apb_state_reg == APB_ACCESS && psel && penable) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
  end

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sink1_level_config_reg <= LEVEL_RST; // [R11]
      sink2_level_config_reg <= LEVEL_RST; // [R11]
    end else if (write_fire) begin
      if (reg_index == IDX_SINK1_LEVEL) begin
        sink1_level_config_reg <= pwdata[7:0]; // [R13]
      end
      if (reg_index == IDX_SINK2_LEVEL) begin
        sink2_level_config_reg <= pwdata[7:0]; // [R1]
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sink1_blink_timing_reg <= TIMING_RST; // [R10]
      sink2_blink_timing_reg <= TIMING_RST; // [R10]
    end else if (write_fire) begin
      if (reg_index == IDX_SINK1_TIME) begin
        sink1_blink_timing_reg <= pwdata[7:0]; // [R12]
      end
      if (reg_index == IDX_SINK2_TIME) begin
        sink2_blink_timing_reg <= pwdata[7:0]; // [R8] [R9]
      end
    end
  end

  // The root clock mirror bit is read only; writes to it are dropped.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      global_sink_enable_reg <= GLOBAL_EN_RST;
    end else if (write_fire && reg_index == IDX_SINK_TOP) begin
      global_sink_enable_reg <= pwdata[GLOBAL_EN_BIT]; // [R14]
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      first_cycle_reg <= 1'b1;
    end else begin
      first_cycle_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // Root clock
  // ****************************************************************
  // Derived from mclk, so it needs no synchroniser; the tick marks its rising edge.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      root_cnt_reg  <= '0;
      root_clk_reg  <= 1'b0;
      root_tick_reg <= 1'b0;
    end else begin
      root_cnt_reg  <= (root_cnt_reg == ROOT_CW'(ROOT_DIV - 1)) ? '0 : root_cnt_reg + 1'b1; // [R15]
      root_clk_reg  <= (root_cnt_reg < ROOT_CW'(ROOT_HIGH)); // [R15]
      root_tick_reg <= (root_cnt_reg == '0);
    end
  end

  // ****************************************************************
  // Channels
  // ****************************************************************
  led_blink_channel u_channel1 (
    .mclk             (mclk),
    .sys_rst          (sys_rst),
    .root_tick        (root_tick_reg),
    .global_enable    (global_sink_enable_reg),
    .range_select     (range_select_ch1),
    .polarity_invert  (polarity_invert_ch1),
    .brightness_level (brightness_level_ch1),
    .blink_period     (blink_period_ch1),
    .blink_duty       (blink_duty_ch1),
    .sink_on          (led_sink_out1),
    .sink_current     (sink_current_ch1)
  );

  led_blink_channel u_channel2 (
    .mclk             (mclk),
    .sys_rst          (sys_rst),
    .root_tick        (root_tick_reg),
    .global_enable    (global_sink_enable_reg),
    .range_select     (range_select_ch2),
    .polarity_invert  (polarity_invert_ch2),
    .brightness_level (brightness_level_ch2),
    .blink_period     (blink_period_ch2),
    .blink_duty       (blink_duty_ch2),
    .sink_on          (led_sink_out2),
    .sink_current     (sink_current_ch2)
  );

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_global_gate: assert property (@(posedge mclk) disable iff (sys_rst) // [R14]
    !global_sink_enable_reg |=> !led_sink_out1 && !led_sink_out2 && sink_current_ch1 == 8'h00
    && sink_current_ch2 == 8'h00)
    else $error("sink conducts while globally disabled");

  a_range_off: assert property (@(posedge mclk) disable iff (sys_rst) // [R1]
    range_select_ch1 == RANGE_OFF |=> !led_sink_out1 && sink_current_ch1 == 8'h00)
    else $error("disabled range still drives the sink");

  a_step_low: assert property (@(posedge mclk) disable iff (sys_rst) // [R2]
    range_select_ch1 == RANGE_3P2 ##1 led_sink_out1
    |-> sink_current_ch1 == {3'h0, $past(brightness_level_ch1)} + 8'h01)
    else $error("wrong current in the 3.2 mA range");

  a_step_mid: assert property (@(posedge mclk) disable iff (sys_rst) // [R3]
    range_select_ch2 == RANGE_6P4 ##1 led_sink_out2
    |-> sink_current_ch2 == ({3'h0, $past(brightness_level_ch2)} + 8'h01) << 1)
    else $error("wrong current in the 6.4 mA range");

  a_step_high: assert property (@(posedge mclk) disable iff (sys_rst) // [R4]
    range_select_ch1 == RANGE_12P8 ##1 led_sink_out1
    |-> sink_current_ch1 == ({3'h0, $past(brightness_level_ch1)} + 8'h01) << 2)
    else $error("wrong current in the 12.8 mA range");

  a_full_scale: assert property (@(posedge mclk) disable iff (sys_rst) // [R5]
    (range_select_ch2 == RANGE_12P8 && brightness_level_ch2 == 5'h1f) ##1 led_sink_out2
    |-> sink_current_ch2 == 8'h80)
    else $error("full scale code is not 12.8 mA");

  a_reset_vals: assert property (@(posedge mclk) disable iff (sys_rst) // [R10] [R11]
    first_cycle_reg |-> sink1_level_config_reg == 8'h04 && sink2_level_config_reg == 8'h04
    && sink1_blink_timing_reg == 8'h0f && sink2_blink_timing_reg == 8'h0f)
    else $error("configuration not at reset value");

  a_timing_write: assert property (@(posedge mclk) disable iff (sys_rst) // [R12]
    (write_fire && reg_index == IDX_SINK1_TIME) |=> sink1_blink_timing_reg == $past(pwdata[7:0]))
    else $error("channel one timing write lost");

  a_root_status: assert property (@(posedge mclk) disable iff (sys_rst) // [R15]
    (setup_take && !pwrite && reg_index == IDX_SINK_TOP) |=> prdata[ROOT_STAT_BIT] == $past(root_clk_reg))
    else $error("status does not mirror the root clock");

  a_root_edge: assert property (@(posedge mclk) disable iff (sys_rst) // [R15]
    root_tick_reg |-> root_clk_reg && !$past(root_clk_reg))
    else $error("root tick not on the root clock rising edge");

  a_apb_answer: assert property (@(posedge mclk) disable iff (sys_rst)
    setup_take |=> pready ##1 !pready)
    else $error("APB answer not a single access cycle");

  a_apb_error: assert property (@(posedge mclk) disable iff (sys_rst)
    (setup_take && !index_known) |=> pslverr && pready)
    else $error("unmapped access not flagged");

  c_ch1_on: cover property (@(posedge mclk) disable iff (sys_rst)
    !led_sink_out1 ##1 led_sink_out1);
  c_ch2_inverted: cover property (@(posedge mclk) disable iff (sys_rst)
    polarity_invert_ch2 && led_sink_out2);
  c_back_to_back: cover property (@(posedge mclk) disable iff (sys_rst)
    setup_take ##2 setup_take);

endmodule : dual_led_sink_blink_pwm

/* File: design/led_blink_channel.sv */
// One blink channel: phase counter on root ticks and the sink drive it produces.
`timescale 1ns/1ns
module led_blink_channel
  import led_sink_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  // Timing and configuration
  input  wire logic       root_tick,
  input  wire logic       global_enable,
  input  wire logic [1:0] range_select,
  input  wire logic       polarity_invert,
  input  wire logic [4:0] brightness_level,
  input  wire logic [3:0] blink_period,
  input  wire logic [3:0] blink_duty,
  // Sink drive
  output logic            sink_on,
  output logic [7:0]      sink_current
);

  logic               active;
  logic               on_next;
  logic [PHASE_W-1:0] phase_reg;
  logic [PHASE_W-1:0] phase_last;

  assign active     = global_enable && (range_select != RANGE_OFF); // [R1] [R14]
  assign phase_last = period_ticks(blink_period) - 10'h001; // [R8] [R16]
  // The compare is against the whole period, so duty 0xf keeps the sink steady.
  assign on_next    = active && ((phase_reg < duty_ticks(blink_period, blink_duty)) ^ polarity_invert); // [R6] [R7] [R9]

  // A held channel starts its pattern at the period start once it is enabled.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      phase_reg <= '0;
    end else if (!active) begin
      phase_reg <= '0;
    end else if (root_tick) begin
      phase_reg <= (phase_reg >= phase_last) ? '0 : phase_reg + 10'h001; // [R16]
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sink_on      <= 1'b0;
      sink_current <= 8'h00;
    end else begin
      sink_on      <= on_next;
      sink_current <= on_next ? sink_current_code(range_select, brightness_level) : 8'h00; // [R5]
    end
  end

  a_period_wrap: assert property (@(posedge mclk) disable iff (sys_rst) // [R16]
    (active && root_tick && phase_reg == phase_last) |=> phase_reg == '0)
    else $error("phase did not restart at period end");
  a_period_start: assert property (@(posedge mclk) disable iff (sys_rst) // [R6] [R7]
    (active && phase_reg == '0) |=> sink_on == !$past(polarity_invert))
    else $error("wrong sink level at period start");
  a_full_duty: assert property (@(posedge mclk) disable iff (sys_rst) // [R9]
    (active && blink_duty == 4'hf) |=> sink_on == !$past(polarity_invert))
    else $error("full duty toggled the sink");
  c_wrap: cover property (@(posedge mclk) disable iff (sys_rst)
    active && root_tick && phase_reg == phase_last);

endmodule : led_blink_channel

/* File: testbench/led_load_model.sv */
// Model of an external LED hanging on one current sink.
`timescale 1ns/1ns
module led_load_model (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  // Sink side
  input  wire logic       sink_on,
  input  wire logic [7:0] sink_current,
  input  wire logic       clear,
  // Observation
  output int unsigned     lit_cycles,
  output logic [7:0]      last_level
);
  // The LED lights only while the sink conducts a nonzero current.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      lit_cycles <= 0;
      last_level <= 8'h00;
    end else if (clear) begin
      lit_cycles <= 0;
    end else if (sink_on && sink_current != 8'h00) begin
      lit_cycles <= lit_cycles + 1;
      last_level <= sink_current;
    end
  end
endmodule : led_load_model

/* File: testbench/testbench.sv */
// Self-checking bench of the dual LED sink blink block.
`timescale 1ns/1ns
module testbench;
  import led_sink_pkg::*;
  localparam int unsigned DIV = 20;
  logic        mclk, sys_rst, psel, penable, pwrite, clr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic        pready, pslverr, out1, out2, er;
  logic [7:0]  cur1, cur2, lv1, lv2;
  int unsigned err_total, n_compared, lit1, lit2, hi;
  logic [3:0]  p, d;
  logic [1:0]  r;
  logic        inv;
  logic [7:0]  wv [4];

  dual_led_sink_blink_pwm #(.ROOT_DIV(DIV), .ROOT_HIGH(2)) u_dut (
    .mclk(mclk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .led_sink_out1(out1), .sink_current_ch1(cur1),
    .led_sink_out2(out2), .sink_current_ch2(cur2));
  led_load_model u_led1 (.mclk(mclk), .sys_rst(sys_rst), .sink_on(out1),
    .sink_current(cur1), .clear(clr), .lit_cycles(lit1), .last_level(lv1));
  led_load_model u_led2 (.mclk(mclk), .sys_rst(sys_rst), .sink_on(out2),
    .sink_current(cur2), .clear(clr), .lit_cycles(lit2), .last_level(lv2));

  always #4 mclk = ~mclk;

  // ****************************************************************
  // Tasks and expectation functions
  // ****************************************************************
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // Holds the request until pready is seen high at a rising edge.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] wd);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h000000, wd};
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      err_total++;
      $display("MISMATCH t=%0t no ready", $time);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function automatic logic [7:0] exp_cur(input logic [1:0] rr, input logic [4:0] b);
    return (rr == 2'h0) ? 8'h00 : ((8'h01 + b) << (rr - 1));
  endfunction : exp_cur

  function automatic int unsigned exp_lit(input logic [3:0] pp, input logic [3:0] dd, input logic iv);
    int unsigned pt, dt;
    pt = (pp + 1) * 32;
    dt = (dd + 1) * (pp + 1) * 2;
    return (iv ? pt - dt : dt) * DIV;
  endfunction : exp_lit

  // Restarts a channel at period start and counts lit cycles over one period.
  task automatic blink(input int ch, input logic [1:0] rr, input logic iv, input logic [4:0] b);
    logic [11:0] base;
    int unsigned e;
    base = 12'h100 + 12'(ch * 8);
    apb(1, base + 12'h004, {p, d});
    apb(1, base, {2'h0, iv, b});
    apb(1, base, {rr, iv, b});
    repeat (2) @(posedge mclk);
    #1 chk(ch ? out2 : out1, (rr != 0) && !iv, "start");
    clr <= 1'b1;
    @(posedge mclk);
    clr <= 1'b0;
    repeat ((p + 1) * 32 * DIV) @(posedge mclk);
    e = (rr == 0) ? 0 : exp_lit(p, d, iv);
    #1 chk(ch ? lit2 : lit1, e, "lit");
    if (e != 0) chk(ch ? lv2 : lv1, exp_cur(rr, b), "level");
  endtask : blink

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    mclk = 0; sys_rst = 1; psel = 0; penable = 0; pwrite = 0; clr = 0;
    paddr = 12'h000; pwdata = 32'h0; pstrb = 4'hf;
    err_total = 0; n_compared = 0;
    void'($urandom(31));
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    apb(0, 12'h100, 0); chk(rd, 32'h04, "rst l1");
    apb(0, 12'h104, 0); chk(rd, 32'h0f, "rst t1");
    apb(0, 12'h108, 0); chk(rd, 32'h04, "rst l2");
    apb(0, 12'h10c, 0); chk(rd, 32'h0f, "rst t2");
    apb(0, 12'h110, 0); chk(rd & 32'hfffffffd, 32'h0, "rst top");
    apb(0, 12'h114, 0); chk({er, rd[30:0]}, 32'h80000000, "unmapped");
    for (int i = 0; i < 4; i++) begin
      wv[i] = 8'($urandom);
      apb(1, 12'h100 + 12'(i * 4), wv[i]);
      apb(0, 12'h100 + 12'(i * 4), 0); chk(rd, {24'h000000, wv[i]}, "rw");
    end
    pstrb <= 4'h0;
    apb(1, 12'h100, 8'h55); apb(0, 12'h100, 0); chk(rd, {24'h000000, wv[0]}, "pstrb");
    pstrb <= 4'hf;
    // Global enable off must keep a full-duty, enabled channel dark.
    p = 0; d = 4'hf;
    apb(1, 12'h110, 8'h00);
    apb(1, 12'h104, 8'h0f); apb(1, 12'h100, 8'hdf);
    repeat (4) @(posedge mclk);
    #1 chk({out1, cur1}, 9'h0, "global off");
    apb(1, 12'h110, 8'hff); apb(0, 12'h110, 0); chk(rd & 32'hfffffffd, 32'h1, "top rw");
    // Twenty reads three cycles apart visit every phase of the root clock once.
    hi = 0;
    repeat (20) begin
      apb(0, 12'h110, 0);
      hi += rd[1];
    end
    chk(hi, 2, "root high");
    for (int k = 0; k < 4; k++) begin
      blink(k % 2, 2'(k), 1'b0, 5'($urandom));
    end
    p = 1; d = 0;
    blink(0, 2'h3, 1'b1, 5'h1f);
    p = 0; d = 4'hf;
    blink(1, 2'h1, 1'b1, 5'h00);
    repeat (5) begin
      p = 4'($urandom_range(1, 0));
      d = 4'($urandom_range(14, 0));
      blink($urandom_range(1, 0), 2'($urandom_range(3, 1)), 1'($urandom), 5'($urandom));
    end
    sys_rst <= 1'b1;
    @(posedge mclk);
    sys_rst <= 1'b0;
    #1 chk({out1, out2, cur1, cur2}, 18'h0, "reset outs");
    apb(0, 12'h108, 0); chk(rd, 32'h04, "rst l2 again");
    wrap_up();
  end

  initial begin
    #(8 * 100000);
    err_total++;
    $display("MISMATCH t=%0t watchdog", $time);
    wrap_up();
  end
endmodule : testbench
